// ---- rtl/lfacc_cfg.svh ----
// register offsets, field positions and reset values of the loop-0 fast-acquisition/clear block
//------------------------------------------------------------------------------
// Summary of operation
// - first-only bit blocks acquisition once done
// - all qualifiers zero acts as all one
// - from-holdover bit allows acquisition on holdover exit
// - from-freerun bit allows acquisition on freerun exit
// - automute clear strobe re-arms channel automute
// - muting re-armed until unmute condition met
// - clear-done strobe resets done flag, self-clears
// - clear-history drops available flag, erases history
// - visible history holds until new average
// - autosync one-shot re-arms sync machine, self-clears
// - autosync fires once unless re-armed
// - mode 01b re-arm syncs now if analog locked
// - no-output bit allows acquisition only before sync
//------------------------------------------------------------------------------
`ifndef LFACC_CFG_SVH
`define LFACC_CFG_SVH
// apb byte addresses are four times the register index
`define LFACC_IDX_QUAL       16'h2106
`define LFACC_IDX_CLR        16'h2107
`define LFACC_ADDR_QUAL      18'h0_8418
`define LFACC_ADDR_CLR       18'h0_841C
`define LFACC_ADDR_STAT      18'h0_8420
`define LFACC_ADDR_IRQ_STAT  18'h0_8424
`define LFACC_ADDR_IRQ_MASK  18'h0_8428
`define LFACC_ADDR_MODE      18'h0_842C
// qualifier fields
`define LFACC_Q_FREERUN      0
`define LFACC_Q_HOLDOVER     1
`define LFACC_Q_FIRST        2
`define LFACC_Q_NOOUT        3
// clear strobe fields
`define LFACC_C_ONESHOT      0
`define LFACC_C_HIST         1
`define LFACC_C_DONE         3
`define LFACC_C_MUTE         4
// mode register fields
`define LFACC_M_SYNC_LO      0
`define LFACC_M_SYNC_HI      1
// event bits in irq status
`define LFACC_E_DONE         0
`define LFACC_E_HIST         1
`define LFACC_E_SYNC         2
`define LFACC_E_FAST         3
`define LFACC_RST_BYTE       8'h00
`define LFACC_SYNC_IMMEDIATE 2'h1
`endif

// ---- rtl/lfacc_pkg.sv ----
// types of the loop-0 fast-acquisition/clear block
package lfacc_pkg;
   // sync machine state
   typedef enum logic [0:0] {
      LFACC_ARMED = 1'b0,   // waiting for the chosen autosync condition
      LFACC_SPENT = 1'b1    // fired once, waits for a re-arm
   } lfacc_sync_t;

   // whole state of the block
   typedef struct packed {
      logic [3:0]  qual_reg;      // fast-acquisition qualifier bits
      logic [1:0]  sync_mode_reg; // autosync mode field
      logic [3:0]  irq_stat_reg;  // sticky events
      logic [3:0]  irq_mask_reg;  // interrupt enables
      logic        done_reg;      // fast acquisition done flag
      logic        hist_av_reg;   // history available flag
      logic        mute_reg;      // outputs held muted
      logic        synced_reg;    // some output has received a sync
      lfacc_sync_t sync_st_reg;   // autosync state
      logic        sync_pulse_reg;// output sync strobe
      logic        hist_clr_reg;  // history erase strobe
      logic [31:0] prdata_reg;    // read data
      logic [2:0]  hold_s1_reg;   // holdover-active pin synchroniser
      logic [2:0]  free_s1_reg;   // freerun-active pin synchroniser
      logic [2:0]  lock_s1_reg;   // analog lock pin synchroniser
      logic        hold_reg;      // filtered holdover level
      logic        free_reg;      // filtered freerun level
      logic        lock_reg;      // filtered analog lock level
   } lfacc_state_t;
endpackage

// ---- rtl/lfacc_top.sv ----
// loop-0 fast-acquisition qualifiers, clear strobes and autosync re-arm with apb access
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "lfacc_cfg.svh"
module lfacc_top (
   input  wire logic        clk_sys_i,          // system clock, 10 MHz
   input  wire logic        rst_i,              // synchronous reset, active high
   input  wire logic        psel_i,             // apb select
   input  wire logic        penable_i,          // apb access phase
   input  wire logic        pwrite_i,           // apb direction
   input  wire logic [17:0] paddr_i,            // apb byte address
   input  wire logic [31:0] pwdata_i,           // apb write data
   output logic             pready_o,           // apb ready
   output logic [31:0]      prdata_o,           // apb read data
   output logic             pslverr_o,          // apb error on unmapped address
   input  wire logic        holdover_active_i,  // digital_loop_zero in holdover (async pin)
   input  wire logic        freerun_active_i,   // digital_loop_zero in freerun (async pin)
   input  wire logic        analog_loop_zero_lock_i, // analog loop lock (async pin)
   input  wire logic        fast_acq_complete_i,// fast acquisition sequence finished
   input  wire logic        unmute_cond_i,      // selected auto-unmute condition met
   input  wire logic        autosync_cond_i,    // selected autosync condition met
   input  wire logic        history_avg_ready_i,// new tuning-word average computed
   output logic             fast_acq_start_o,   // start a loop-0 fast acquisition
   output logic             fast_acq_allow_o,   // fast acquisition currently permitted
   output logic             fast_acq_done_o,    // fast acquisition done flag
   output logic             history_avail_o,    // history available flag
   output logic             history_erase_o,    // erase internal history values
   output logic             outputs_muted_o,    // channel outputs held muted
   output logic             output_sync_o,      // output sync strobe
   output logic             irq_o               // level interrupt
);
   //---------------------------------------------------------------------------
   // state and decode
   //---------------------------------------------------------------------------
   lfacc_pkg::lfacc_state_t s_reg;   // registered state
   lfacc_pkg::lfacc_state_t s_next;  // next state
   logic       wr_en;                // write takes effect this edge
   logic       rd_en;                // read data taken this edge
   logic       hit;                  // address maps to a register
   logic [3:0] q_eff;                // effective qualifiers
   logic       hold_exit;            // holdover left
   logic       free_exit;            // freerun left
   logic       sync_fire;            // sync event this cycle
   logic [3:0] events;               // event set this cycle

   // true for every address of the register map
   function automatic logic addr_hit(input logic [17:0] a);
      addr_hit = (a == `LFACC_ADDR_QUAL) || (a == `LFACC_ADDR_CLR) ||
                 (a == `LFACC_ADDR_STAT) || (a == `LFACC_ADDR_IRQ_STAT) ||
                 (a == `LFACC_ADDR_IRQ_MASK) || (a == `LFACC_ADDR_MODE);
   endfunction

   // agreed level from the last two stages of a three-stage synchroniser
   // the third stage costs a cycle of lag but filters a single-cycle glitch
   function automatic logic filt(input logic [2:0] sh, input logic prev);
      filt = (sh[1] == sh[2]) ? sh[2] : prev;
   endfunction

   assign hit   = addr_hit(paddr_i);
   assign wr_en = psel_i && penable_i && pwrite_i;
   // read data is loaded in the setup cycle, so it already stands
   // at the access edge where the master takes it
   assign rd_en = psel_i && !penable_i && !pwrite_i;

   //---------------------------------------------------------------------------
   // fast acquisition qualification
   //---------------------------------------------------------------------------
   // all-zero qualifiers enable every mode
   assign q_eff     = (s_reg.qual_reg == 4'h0) ? 4'hF : s_reg.qual_reg;
   assign hold_exit = s_reg.hold_reg && !filt(s_reg.hold_s1_reg, s_reg.hold_reg);
   assign free_exit = s_reg.free_reg && !filt(s_reg.free_s1_reg, s_reg.free_reg);
   // permission: once-only and before-sync gating
   assign fast_acq_allow_o = !(q_eff[`LFACC_Q_FIRST] && s_reg.done_reg) &&
                             !(q_eff[`LFACC_Q_NOOUT] && s_reg.synced_reg);
   // start on the enabled mode exits
   assign fast_acq_start_o = fast_acq_allow_o &&
                             ((hold_exit && q_eff[`LFACC_Q_HOLDOVER]) ||
                              (free_exit && q_eff[`LFACC_Q_FREERUN]));

   //---------------------------------------------------------------------------
   // next state
   //---------------------------------------------------------------------------
   always_comb begin
      logic [7:0] wb;   // written low byte
      logic       rearm;// one-shot written this edge
      wb        = pwdata_i[7:0];
      rearm     = 1'b0;
      s_next    = s_reg;
      sync_fire = 1'b0;
      // pin synchronisers, first stage feeds only the second
      s_next.hold_s1_reg = {s_reg.hold_s1_reg[1:0], holdover_active_i};
      s_next.free_s1_reg = {s_reg.free_s1_reg[1:0], freerun_active_i};
      s_next.lock_s1_reg = {s_reg.lock_s1_reg[1:0], analog_loop_zero_lock_i};
      s_next.hold_reg    = filt(s_reg.hold_s1_reg, s_reg.hold_reg);
      s_next.free_reg    = filt(s_reg.free_s1_reg, s_reg.free_reg);
      s_next.lock_reg    = filt(s_reg.lock_s1_reg, s_reg.lock_reg);
      s_next.hist_clr_reg   = 1'b0;
      s_next.sync_pulse_reg = 1'b0;
      // completion sets the sticky done flag
      if (fast_acq_complete_i) begin
         s_next.done_reg = 1'b1;
      end
      // new average marks history available; visible word left alone till then
      if (history_avg_ready_i) begin
         s_next.hist_av_reg = 1'b1;
      end
      // unmute once the chosen condition holds
      if (unmute_cond_i) begin
         s_next.mute_reg = 1'b0;
      end
      // register writes; clear strobes are not stored, so they read back zero
      // only the low byte of the write data carries fields
      if (wr_en) begin
         unique case (paddr_i)
            `LFACC_ADDR_QUAL: s_next.qual_reg = wb[3:0];
            `LFACC_ADDR_MODE: s_next.sync_mode_reg = wb[1:0];
            `LFACC_ADDR_IRQ_MASK: s_next.irq_mask_reg = wb[3:0];
            `LFACC_ADDR_IRQ_STAT: s_next.irq_stat_reg = s_reg.irq_stat_reg & ~wb[3:0];
            `LFACC_ADDR_CLR: begin
               // completion in the same cycle wins over the clear
               if (wb[`LFACC_C_DONE] && !fast_acq_complete_i) begin
                  s_next.done_reg = 1'b0;
               end
               if (wb[`LFACC_C_HIST]) begin
                  // a new average in the same cycle wins over the clear
                  if (!history_avg_ready_i) begin
                     s_next.hist_av_reg = 1'b0;
                  end
                  s_next.hist_clr_reg = 1'b1;
               end
               if (wb[`LFACC_C_MUTE]) begin
                  // mute re-armed until the unmute condition recurs
                  s_next.mute_reg = !unmute_cond_i;
               end
               rearm = wb[`LFACC_C_ONESHOT];
            end
            default: ;
         endcase
      end
      // autosync machine
      unique case (s_reg.sync_st_reg)
         lfacc_pkg::LFACC_ARMED: begin
            if (autosync_cond_i) begin
               sync_fire = 1'b1;
            end
         end
         lfacc_pkg::LFACC_SPENT: begin
            if (rearm) begin
               s_next.sync_st_reg = lfacc_pkg::LFACC_ARMED;
            end
         end
      endcase
      // immediate sync on re-arm in mode 01b while locked
      if (rearm && s_reg.sync_mode_reg == `LFACC_SYNC_IMMEDIATE && s_reg.lock_reg) begin
         sync_fire = 1'b1;
      end
      if (sync_fire) begin
         s_next.sync_pulse_reg = 1'b1;
         s_next.synced_reg     = 1'b1;
         s_next.sync_st_reg    = lfacc_pkg::LFACC_SPENT;
      end
      // sticky events, set wins over a write-one clear
      // events gathered here so the status update sees this cycle's sync
      events = {fast_acq_start_o, sync_fire, history_avg_ready_i, fast_acq_complete_i};
      s_next.irq_stat_reg = s_next.irq_stat_reg | events;
      // read data
      if (rd_en) begin
         s_next.prdata_reg = 32'h0000_0000;
         unique case (paddr_i)
            `LFACC_ADDR_QUAL: s_next.prdata_reg[3:0] = s_reg.qual_reg;
            `LFACC_ADDR_MODE: s_next.prdata_reg[1:0] = s_reg.sync_mode_reg;
            `LFACC_ADDR_IRQ_MASK: s_next.prdata_reg[3:0] = s_reg.irq_mask_reg;
            `LFACC_ADDR_IRQ_STAT: s_next.prdata_reg[3:0] = s_reg.irq_stat_reg;
            `LFACC_ADDR_STAT: s_next.prdata_reg[5:0] = {
               s_reg.sync_st_reg == lfacc_pkg::LFACC_ARMED,
               s_reg.synced_reg, s_reg.lock_reg, s_reg.mute_reg, s_reg.hist_av_reg,
               s_reg.done_reg};
            default: ;
         endcase
      end
   end


   //---------------------------------------------------------------------------
   // state register
   //---------------------------------------------------------------------------
   // one register for the whole state; reset is synchronous
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s_reg          <= '0;
         s_reg.mute_reg <= 1'b1; // outputs start muted until unmute condition
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs: handshake and interrupt are combinational, data from flops
   // pready never waits, so every access completes in one access cycle
   assign pready_o        = 1'b1;
   assign pslverr_o       = psel_i && penable_i && !hit;
   assign prdata_o        = s_reg.prdata_reg;
   assign fast_acq_done_o = s_reg.done_reg;
   assign history_avail_o = s_reg.hist_av_reg;
   assign history_erase_o = s_reg.hist_clr_reg;
   assign outputs_muted_o = s_reg.mute_reg;
   assign output_sync_o   = s_reg.sync_pulse_reg;
   assign irq_o           = |(s_reg.irq_stat_reg & s_reg.irq_mask_reg);

   //---------------------------------------------------------------------------
   // assertions
   //---------------------------------------------------------------------------
   a_first_blocks: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (s_reg.qual_reg == 4'h4 && s_reg.done_reg) |-> !fast_acq_allow_o)
      else $error("first-only did not block acquisition");
   a_zero_enables: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (s_reg.qual_reg == 4'h0 && !s_reg.done_reg && !s_reg.synced_reg && hold_exit)
      |-> fast_acq_start_o)
      else $error("all-zero qualifiers not treated as all enabled");
   a_hold_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (s_reg.qual_reg == 4'h1 && hold_exit && !free_exit) |-> !fast_acq_start_o)
      else $error("holdover exit started while disabled");
   a_free_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (s_reg.qual_reg == 4'h2 && free_exit && !hold_exit) |-> !fast_acq_start_o)
      else $error("freerun exit started while disabled");
   a_mute_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr_en && paddr_i == `LFACC_ADDR_CLR && pwdata_i[4] && !unmute_cond_i)
      |=> outputs_muted_o)
      else $error("automute clear did not re-arm muting");
   a_done_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr_en && paddr_i == `LFACC_ADDR_CLR && pwdata_i[3] && !fast_acq_complete_i)
      |=> !fast_acq_done_o)
      else $error("done flag not cleared");
   a_hist_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr_en && paddr_i == `LFACC_ADDR_CLR && pwdata_i[1] && !history_avg_ready_i)
      |=> (!history_avail_o && history_erase_o))
      else $error("history clear ignored");
   a_sync_once: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      output_sync_o && !(wr_en && paddr_i == `LFACC_ADDR_CLR && pwdata_i[0])
      |=> !output_sync_o)
      else $error("autosync fired twice without re-arm");
   a_noout_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (s_reg.qual_reg[3] && s_reg.synced_reg) |-> !fast_acq_start_o)
      else $error("acquisition after outputs synced");
   c_start: cover property (@(posedge clk_sys_i) fast_acq_start_o);
   c_sync: cover property (@(posedge clk_sys_i) output_sync_o);
   c_irq: cover property (@(posedge clk_sys_i) irq_o);
   c_erase: cover property (@(posedge clk_sys_i) history_erase_o);
   c_sync_now: cover property (@(posedge clk_sys_i)
      output_sync_o && s_reg.sync_mode_reg == `LFACC_SYNC_IMMEDIATE);

   //---------------------------------------------------------------------------
   // sticky flags and strobes
   //---------------------------------------------------------------------------
   a_done_sets: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      fast_acq_complete_i
      |=> fast_acq_done_o)
      else $error("completion did not set the done flag");
   a_done_sticky: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (fast_acq_done_o && !(wr_en && paddr_i == `LFACC_ADDR_CLR && pwdata_i[3]))
      |=> fast_acq_done_o)
      else $error("done flag dropped without a clear");
   a_hist_sets: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      history_avg_ready_i
      |=> history_avail_o)
      else $error("new average did not mark history available");
   a_hist_sticky: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (history_avail_o && !(wr_en && paddr_i == `LFACC_ADDR_CLR && pwdata_i[1]))
      |=> history_avail_o)
      else $error("history flag dropped without a clear");
   a_erase_once: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      history_erase_o
      |=> !history_erase_o)
      else $error("history erase strobe longer than one cycle");
   a_irq_sets: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      fast_acq_complete_i
      |=> s_reg.irq_stat_reg[`LFACC_E_DONE])
      else $error("completion event not recorded");

   //---------------------------------------------------------------------------
   // autosync, muting, qualifiers and read data
   //---------------------------------------------------------------------------
   a_rearm_arms: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr_en && paddr_i == `LFACC_ADDR_CLR && pwdata_i[0])
      |=> (s_reg.sync_st_reg == lfacc_pkg::LFACC_ARMED || output_sync_o))
      else $error("one-shot write did not re-arm autosync");
   a_sync_now: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr_en && paddr_i == `LFACC_ADDR_CLR && pwdata_i[0] && s_reg.lock_reg &&
       s_reg.sync_mode_reg == `LFACC_SYNC_IMMEDIATE)
      |=> output_sync_o)
      else $error("re-arm in immediate mode did not sync");
   a_unmute_cond: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      unmute_cond_i
      |=> !outputs_muted_o)
      else $error("outputs stayed muted after unmute condition");
   a_hold_enabled: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (s_reg.qual_reg == 4'h2 && hold_exit && fast_acq_allow_o)
      |-> fast_acq_start_o)
      else $error("holdover exit did not start acquisition");
   a_free_enabled: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (s_reg.qual_reg == 4'h1 && free_exit && fast_acq_allow_o)
      |-> fast_acq_start_o)
      else $error("freerun exit did not start acquisition");
   a_clr_reads_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (psel_i && !penable_i && !pwrite_i && paddr_i == `LFACC_ADDR_CLR)
      |=> (prdata_o == 32'h0000_0000))
      else $error("clear strobes did not read back zero");
   a_unmapped_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (psel_i && !penable_i && !pwrite_i && !hit)
      |=> (prdata_o == 32'h0000_0000))
      else $error("unmapped read returned nonzero data");
endmodule

// ---- bench/lfacc_tb.sv ----
// self-checking bench for the loop-0 fast-acquisition and clear block
`timescale 1ns/1ps
`include "lfacc_cfg.svh"
module tb;
   //---------------------------------------------------------------
   // stimulus and observed signals
   //---------------------------------------------------------------
   logic        clk_sys_i = 1'b0, rst_i = 1'b1;          // clock, reset
   logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [17:0] paddr_i = 18'h0_0000;                   // apb address
   logic [31:0] pwdata_i = 32'h0000_0000;               // apb write data
   logic        holdover_active_i = 1'b0, freerun_active_i = 1'b0;
   logic        analog_loop_zero_lock_i = 1'b0, fast_acq_complete_i = 1'b0;
   logic        unmute_cond_i = 1'b0, autosync_cond_i = 1'b0;
   logic        history_avg_ready_i = 1'b0;
   logic        pready_o, pslverr_o, fast_acq_start_o, fast_acq_allow_o;
   logic        fast_acq_done_o, history_avail_o, history_erase_o;
   logic        outputs_muted_o, output_sync_o, irq_o;
   logic [31:0] prdata_o, rd;                           // read data
   logic        er;                                     // captured slave error
   int          n_mismatch = 0, samples_checked = 0;    // report counters
   int          n_start = 0, n_sync = 0, n_erase = 0;   // pulse tallies

   lfacc_top uut (.clk_sys_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .holdover_active_i,
      .freerun_active_i, .analog_loop_zero_lock_i, .fast_acq_complete_i,
      .unmute_cond_i, .autosync_cond_i, .history_avg_ready_i, .fast_acq_start_o,
      .fast_acq_allow_o, .fast_acq_done_o, .history_avail_o, .history_erase_o,
      .outputs_muted_o, .output_sync_o, .irq_o);

   // 10 MHz clock
   initial begin
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   // pulses are tallied so short strobes cannot slip between checks
   always @(posedge clk_sys_i) begin
      if (fast_acq_start_o === 1'b1) n_start++;
      if (output_sync_o === 1'b1) n_sync++;
      if (history_erase_o === 1'b1) n_erase++;
   end

   //---------------------------------------------------------------
   // shared tasks
   //---------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= wr; paddr_i <= a; pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      // no cycle count assumed: only the watchdog ends a hung wait
      @(posedge clk_sys_i);
      while (pready_o !== 1'b1) @(posedge clk_sys_i);
      er = pslverr_o;
      rd = prdata_o;      // data and error taken at the ready edge
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_sys_i); // written state settles before any check
   endtask

   task automatic pulse_done();
      fast_acq_complete_i <= 1'b1; cyc(1); fast_acq_complete_i <= 1'b0; cyc(2);
   endtask

   // exit of holdover then of freerun under one qualifier setting
   task automatic exit_chk(input logic [3:0] q);
      int s;
      apb(1'b1, `LFACC_ADDR_QUAL, {28'h0, q});
      s = n_start; holdover_active_i <= 1'b1; cyc(6); holdover_active_i <= 1'b0; cyc(8);
      chk("hold_exit", (q[1] || q == 4'h0) ? 32'h1 : 32'h0, 32'(n_start - s));
      s = n_start; freerun_active_i <= 1'b1; cyc(6); freerun_active_i <= 1'b0; cyc(8);
      chk("free_exit", (q[0] || q == 4'h0) ? 32'h1 : 32'h0, 32'(n_start - s));
   endtask

   task automatic results();
      $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      #500000;
      n_mismatch++;
      results();
   end

   //---------------------------------------------------------------
   // main sequence
   //---------------------------------------------------------------
   initial begin
      int s;
      cyc(10);
      rst_i <= 1'b0;
      chk("muted_rst", 32'h1, {31'h0, outputs_muted_o});
      apb(1'b0, `LFACC_ADDR_STAT, 32'h0);
      chk("stat_rst", 32'h24, rd);
      apb(1'b0, `LFACC_ADDR_QUAL, 32'h0);
      chk("qual_rst", 32'h0, rd);
      // done flag against first-only, all-zero qualifiers act as all ones
      chk("allow_idle", 32'h1, {31'h0, fast_acq_allow_o});
      pulse_done();
      chk("done_set", 32'h1, {31'h0, fast_acq_done_o});
      chk("allow_zero", 32'h0, {31'h0, fast_acq_allow_o});
      apb(1'b1, `LFACC_ADDR_QUAL, 32'h2);
      chk("allow_nofirst", 32'h1, {31'h0, fast_acq_allow_o});
      apb(1'b1, `LFACC_ADDR_QUAL, 32'h4);
      chk("allow_first", 32'h0, {31'h0, fast_acq_allow_o});
      apb(1'b1, `LFACC_ADDR_CLR, 32'h8); cyc(2);
      chk("done_clr", 32'h0, {31'h0, fast_acq_done_o});
      chk("allow_after", 32'h1, {31'h0, fast_acq_allow_o});
      apb(1'b0, `LFACC_ADDR_CLR, 32'h0);
      chk("clr_self", 32'h0, rd);
      exit_chk(4'h1);
      exit_chk(4'h2);
      exit_chk(4'h0);
      // no-output qualifier, then autosync once and re-arm
      apb(1'b1, `LFACC_ADDR_QUAL, 32'h8);
      chk("allow_nosync", 32'h1, {31'h0, fast_acq_allow_o});
      for (int k = 0; k < 3; k++) begin
         if (k == 2) apb(1'b1, `LFACC_ADDR_CLR, 32'h1);
         s = n_sync; autosync_cond_i <= 1'b1; cyc(1); autosync_cond_i <= 1'b0; cyc(4);
         chk("sync_cnt", (k == 1) ? 32'h0 : 32'h1, 32'(n_sync - s));
      end
      chk("allow_synced", 32'h0, {31'h0, fast_acq_allow_o});
      // immediate sync on re-arm in mode 01 only when locked
      apb(1'b1, `LFACC_ADDR_MODE, {30'h0, `LFACC_SYNC_IMMEDIATE});
      s = n_sync; apb(1'b1, `LFACC_ADDR_CLR, 32'h1); cyc(6);
      chk("sync_unlocked", 32'h0, 32'(n_sync - s));
      analog_loop_zero_lock_i <= 1'b1; cyc(6);
      s = n_sync; apb(1'b1, `LFACC_ADDR_CLR, 32'h1); cyc(6);
      chk("sync_locked", 32'h1, 32'(n_sync - s));
      // automute clear re-arms muting until the unmute condition
      unmute_cond_i <= 1'b1; cyc(3);
      chk("unmuted", 32'h0, {31'h0, outputs_muted_o});
      unmute_cond_i <= 1'b0; apb(1'b1, `LFACC_ADDR_CLR, 32'h10); cyc(6);
      chk("remuted", 32'h1, {31'h0, outputs_muted_o});
      unmute_cond_i <= 1'b1; cyc(3);
      chk("unmuted2", 32'h0, {31'h0, outputs_muted_o});
      // history clear drops the flag, a new average restores it
      history_avg_ready_i <= 1'b1; cyc(1); history_avg_ready_i <= 1'b0; cyc(2);
      chk("hist_av", 32'h1, {31'h0, history_avail_o});
      s = n_erase; apb(1'b1, `LFACC_ADDR_CLR, 32'h2); cyc(3);
      chk("hist_clr", 32'h0, {31'h0, history_avail_o});
      chk("hist_erase", 32'h1, 32'(n_erase - s));
      history_avg_ready_i <= 1'b1; cyc(1); history_avg_ready_i <= 1'b0; cyc(2);
      chk("hist_new", 32'h1, {31'h0, history_avail_o});
      // sticky status, mask and write-one-to-clear interrupt
      apb(1'b1, `LFACC_ADDR_IRQ_STAT, 32'hF);
      apb(1'b0, `LFACC_ADDR_IRQ_STAT, 32'h0);
      chk("irq_stat_clr", 32'h0, rd);
      pulse_done();
      chk("irq_masked", 32'h0, {31'h0, irq_o});
      apb(1'b1, `LFACC_ADDR_IRQ_MASK, 32'h1); cyc(1);
      chk("irq_on", 32'h1, {31'h0, irq_o});
      apb(1'b1, `LFACC_ADDR_IRQ_STAT, 32'h1); cyc(1);
      chk("irq_off", 32'h0, {31'h0, irq_o});
      // unmapped address answers with an error
      apb(1'b0, 18'h0_0000, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
      chk("unmapped_rd", 32'h0, rd);
      results();
   end
endmodule
